// [unbm_uart.sv]
// Purpose: Full-duplex serial port, eight- and nine-bit frames, multidrop filter
// Assumes: Timer clock enable and reload value come from the outer timer
// Notes:   Control register at 0x98, bit addresses 0x98..0x9F; data at 0x99
//
// Functional notes
// RULE1 - Nine-bit frame: start, eight LSB-first, ninth, stop
// RULE2 - Nine-bit transmit sends tx_ninth_bit as ninth
// RULE3 - Nine-bit receive stores ninth bit; stop ignored
// RULE4 - Writing serial_buffer starts a transmit frame
// RULE5 - Nine-bit: tx_done_flag set at stop start
// RULE6 - Receiver runs only while receive_enable_bit set
// RULE7 - Accept needs rx_done_flag clear, filter needs ninth
// RULE8 - Accept loads latch, rx_ninth_bit, sets rx_done_flag
// RULE9 - Rejected frame changes no latch or flag
// RULE10 - Either done flag raises the interrupt request
// RULE11 - Master marks address frames with ninth bit
// RULE12 - Eight-bit: filter enable demands stop bit one
// RULE13 - Control bit 7 picks eight or nine bits
// RULE14 - Control bit 6 reads one, ignores writes
// RULE15 - Eight-bit: rx_ninth_bit takes stop bit level
// RULE16 - Eight-bit: tx_ninth_bit only stored, not sent
// RULE17 - Eight-bit: tx_done_flag after eighth data bit
// RULE18 - Done flags cleared only by software
// RULE19 - rx_done_flag set when stop bit sampled
// RULE20 - Control at 0x98, each bit addressable
// RULE21 - Eight-bit frame: start, eight LSB-first, stop
// RULE22 - Bit rate is half timer overflow, shared reload
// RULE23 - Start edge reloads the receive timer
// RULE24 - Data reads give latch, writes go transmit
// RULE25 - Transmit ignores receive enable changes
`timescale 1ns/1ns
module unbm_uart (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Special-function bus
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_bit_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    // Baud timer
    input  wire logic       t1_tick_i,
    input  wire logic       t1_run_i,
    input  wire logic [7:0] baud_reload_value_i,
    // Serial line
    input  wire logic       rx_i,
    output logic            tx_o,
    // Status to the core
    output logic            irq_req_o,
    output logic            tx_buf_ready_o
);
    typedef enum logic {RX_IDLE, RX_BUSY} unbm_rx_st_t;

    // Control state
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  rx_latch_q;
    // Transmit path
    logic        tx_busy_q;
    logic [3:0]  tx_cnt_q;
    logic [7:0]  tx_sh_q;
    logic        tx_m9_q;
    logic        tx_tick;
    logic        tx_set;
    logic        tx_pop;
    logic        buf_valid;
    logic [7:0]  buf_data;
    logic        buf_push;
    // Receive path
    logic        rx_s1_q;
    logic        rx_s2_q;
    logic        rx_s3_q;
    unbm_rx_st_t rx_st_q;
    logic [3:0]  rx_cnt_q;
    logic [7:0]  rx_sh_q;
    logic        rx_b9_q;
    logic        rx_m9_q;
    logic        rx_half;
    logic        rx_start;
    logic        rx_stop;
    logic        rx_accept;
    logic        rx_ninth_val;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Index of the stop bit for the chosen frame length
    function automatic logic [3:0] stop_idx(input logic m9);
        stop_idx = m9 ? unbm_pkg::STOP_IDX9 : unbm_pkg::STOP_IDX8;
    endfunction

    // True when addr is one of the eight control bit addresses
    function automatic logic is_ctrl_bit(input logic [7:0] addr);
        is_ctrl_bit = (addr[7:3] == unbm_pkg::CTRL_ADDR[7:3]);
    endfunction

    // ------------------------------------------------------------
    // Baud timers, one shared reload value
    // ------------------------------------------------------------
    unbm_baud #(.W(8)) u_tx_baud (                   // RULE22
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (t1_tick_i),
        .run_i     (t1_run_i),
        .restart_i (1'b0),
        .reload_i  (baud_reload_value_i),
        .half_o    (),
        .bit_o     (tx_tick)
    );

    unbm_baud #(.W(8)) u_rx_baud (                   // RULE22
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (t1_tick_i),
        .run_i     (t1_run_i),
        .restart_i (rx_start),                       // RULE23
        .reload_i  (baud_reload_value_i),
        .half_o    (rx_half),
        .bit_o     ()
    );

    // ------------------------------------------------------------
    // Transmit buffer; a full buffer refuses the write
    // ------------------------------------------------------------
    assign buf_push = sfr_wr_i && (sfr_addr_i == unbm_pkg::SBUF_ADDR); // RULE24

    unbm_fifo2 #(.W(8)) u_tx_buf (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (buf_push),
        .in_data_i   (sfr_wdata_i),
        .in_ready_o  (tx_buf_ready_o),
        .out_valid_o (buf_valid),
        .out_data_o  (buf_data),
        .out_ready_i (!tx_busy_q)
    );

    assign tx_pop = buf_valid && !tx_busy_q;         // RULE4

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    // Start bit goes out at once; later bits follow the bit tick.
    // Mode is frozen per frame, so a mid-frame write cannot tear it.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tx_busy_q <= 1'b0;
            tx_cnt_q  <= 4'h0;
            tx_sh_q   <= 8'h00;
            tx_m9_q   <= 1'b0;
            tx_o      <= 1'b1;
        end
        else if (tx_pop)
        begin
            tx_busy_q <= 1'b1;
            tx_cnt_q  <= 4'h0;
            tx_sh_q   <= buf_data;
            tx_m9_q   <= ctrl_q[unbm_pkg::BIT_FRAME_SEL]; // RULE13
            tx_o      <= 1'b0;
        end
        else if (tx_busy_q && tx_tick)               // RULE25
        begin
            if (tx_cnt_q == stop_idx(tx_m9_q))
            begin
                tx_busy_q <= 1'b0;
                tx_o      <= 1'b1;
            end
            else
            begin
                tx_cnt_q <= tx_cnt_q + 4'h1;
                if (tx_cnt_q + 4'h1 == stop_idx(tx_m9_q))
                    tx_o <= 1'b1;                    // RULE1 RULE21
                else if (tx_cnt_q + 4'h1 == unbm_pkg::NINTH_IDX)
                    tx_o <= ctrl_q[unbm_pkg::BIT_TX_NINTH]; // RULE2 RULE16
                else
                begin
                    tx_o    <= tx_sh_q[0];           // RULE1 RULE21
                    tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                end
            end
        end
    end

    // Done when the stop bit begins, after the last data bit
    assign tx_set = tx_busy_q && tx_tick && (tx_cnt_q + 4'h1 == stop_idx(tx_m9_q)); // RULE5 RULE17

    // ------------------------------------------------------------
    // Receive line synchroniser and start detect
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q; // Edge history reads only the second stage
        end
    end

    assign rx_start = (rx_st_q == RX_IDLE) && ctrl_q[unbm_pkg::BIT_RX_EN]
                      && rx_s3_q && !rx_s2_q;         // RULE6 RULE23

    // ------------------------------------------------------------
    // Receive sampler, mid-bit on the half tick
    // ------------------------------------------------------------
    assign rx_stop = (rx_st_q == RX_BUSY) && rx_half && (rx_cnt_q == stop_idx(rx_m9_q));
    assign rx_ninth_val = rx_m9_q ? rx_b9_q : rx_s2_q; // RULE3 RULE15
    // Filter checks ninth bit, or stop level in short frames
    assign rx_accept = rx_stop && !ctrl_q[unbm_pkg::BIT_RX_DONE]
                       && (!ctrl_q[unbm_pkg::BIT_MDROP] || rx_ninth_val); // RULE7 RULE12

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_st_q  <= RX_IDLE;
            rx_cnt_q <= 4'h0;
            rx_sh_q  <= 8'h00;
            rx_b9_q  <= 1'b0;
            rx_m9_q  <= 1'b0;
        end
        else if (rx_start)
        begin
            rx_st_q  <= RX_BUSY;
            rx_cnt_q <= 4'h0;
            rx_m9_q  <= ctrl_q[unbm_pkg::BIT_FRAME_SEL];
        end
        else if (!ctrl_q[unbm_pkg::BIT_RX_EN])
            rx_st_q <= RX_IDLE;                      // RULE6
        else if ((rx_st_q == RX_BUSY) && rx_half)
        begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'h0 && rx_s2_q)
                rx_st_q <= RX_IDLE;                  // False start, glitch
            else if (rx_cnt_q == stop_idx(rx_m9_q))
                rx_st_q <= RX_IDLE;
            else if (rx_cnt_q == unbm_pkg::NINTH_IDX)
                rx_b9_q <= rx_s2_q;                  // RULE3
            else if (rx_cnt_q != 4'h0)
                rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};  // RULE1 RULE21
        end
    end

    // Receive latch holds its word unless a frame is accepted
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rx_latch_q <= unbm_pkg::SBUF_RESET;
        else if (rx_accept)
            rx_latch_q <= rx_sh_q;                   // RULE8 RULE9
    end

    // ------------------------------------------------------------
    // Control register; hardware sets win over software clears
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (sfr_wr_i && sfr_addr_i == unbm_pkg::CTRL_ADDR)
            ctrl_d = sfr_wdata_i;
        if (sfr_bit_wr_i && is_ctrl_bit(sfr_addr_i))
            ctrl_d[sfr_addr_i[2:0]] = sfr_wdata_i[0]; // RULE20
        ctrl_d[unbm_pkg::BIT_UNUSED] = 1'b1;         // RULE14
        if (tx_set)
            ctrl_d[unbm_pkg::BIT_TX_DONE] = 1'b1;    // RULE5 RULE17
        if (rx_accept)
        begin
            ctrl_d[unbm_pkg::BIT_RX_DONE]  = 1'b1;   // RULE8 RULE19
            ctrl_d[unbm_pkg::BIT_RX_NINTH] = rx_ninth_val; // RULE8 RULE15
        end
    end

    // Flags only fall by a bus write
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl_q <= unbm_pkg::CTRL_RESET;
        else
            ctrl_q <= ctrl_d;                        // RULE18
    end

    // ------------------------------------------------------------
    // Read data and interrupt request
    // ------------------------------------------------------------
    // Transmit word is write-only; data reads return the latch
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sfr_rdata_o <= 8'h00;
            irq_req_o   <= 1'b0;
        end
        else
        begin
            irq_req_o <= ctrl_q[unbm_pkg::BIT_TX_DONE] || ctrl_q[unbm_pkg::BIT_RX_DONE]; // RULE10
            if (sfr_rd_i)
            begin
                if (sfr_addr_i == unbm_pkg::CTRL_ADDR)
                    sfr_rdata_o <= ctrl_q;
                else if (sfr_addr_i == unbm_pkg::SBUF_ADDR)
                    sfr_rdata_o <= rx_latch_q;       // RULE24
                else
                    sfr_rdata_o <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_tx_load;
        tx_pop ##1 (tx_busy_q && !tx_o);
    endsequence

    sequence s_rx_accepted;
        rx_accept ##1 ctrl_q[unbm_pkg::BIT_RX_DONE];
    endsequence

    a_tx_start_bit: assert property (tx_pop |-> s_tx_load) // RULE4
        else $error("write did not start a frame");
    a_tx_done_stop: assert property (tx_set |=> tx_o && ctrl_q[unbm_pkg::BIT_TX_DONE]) // RULE5
        else $error("tx done not set at stop start");
    a_tx_ninth_bit: assert property (tx_busy_q && tx_m9_q && tx_tick
        && tx_cnt_q == 4'h8 |=> tx_o == $past(ctrl_q[unbm_pkg::BIT_TX_NINTH])) // RULE2
        else $error("ninth bit not sent from control");
    a_rx_disabled: assert property (!ctrl_q[unbm_pkg::BIT_RX_EN]
        |=> rx_st_q == RX_IDLE) // RULE6
        else $error("receiver ran while disabled");
    a_flag_no_clear: assert property ($fell(ctrl_q[unbm_pkg::BIT_RX_DONE])
        |-> $past(sfr_wr_i || sfr_bit_wr_i)) // RULE18
        else $error("rx done cleared without write");
    a_accept_load: assert property (s_rx_accepted |-> rx_latch_q == $past(rx_sh_q)
        && ctrl_q[unbm_pkg::BIT_RX_NINTH] == $past(rx_ninth_val)) // RULE8
        else $error("accepted frame not stored");
    a_reject_keep: assert property (rx_stop && !rx_accept |=> $stable(rx_latch_q)) // RULE9
        else $error("rejected frame changed latch");
    a_filter_gate: assert property (rx_stop && ctrl_q[unbm_pkg::BIT_MDROP] && !rx_ninth_val
        && !sfr_wr_i && !sfr_bit_wr_i |=> $stable(rx_latch_q)
        && $stable(ctrl_q[unbm_pkg::BIT_RX_DONE])) // RULE7
        else $error("filter let a frame pass");
    a_bit6_one: assert property (sfr_rd_i && sfr_addr_i == unbm_pkg::CTRL_ADDR
        |=> sfr_rdata_o[unbm_pkg::BIT_UNUSED]) // RULE14
        else $error("unused bit read zero");
    a_irq_follow: assert property (ctrl_q[unbm_pkg::BIT_TX_DONE] |=> irq_req_o) // RULE10
        else $error("interrupt not requested");
endmodule

// [unbm_pkg.sv]
// Purpose: Shared constants of the ninth-bit multidrop serial port
// Assumes: Special-function bus with byte and bit addressing
// Notes:   Field positions index the control register
package unbm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR  = 8'h98; // Also base of bit addresses
    localparam logic [7:0] SBUF_ADDR  = 8'h99;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] SBUF_RESET = 8'h00;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_RX_DONE   = 0;
    localparam int BIT_TX_DONE   = 1;
    localparam int BIT_RX_NINTH  = 2;
    localparam int BIT_TX_NINTH  = 3;
    localparam int BIT_RX_EN     = 4;
    localparam int BIT_MDROP     = 5;
    localparam int BIT_UNUSED    = 6;
    localparam int BIT_FRAME_SEL = 7;

    // ------------------------------------------------------------
    // Frame layout, index 0 is the start bit
    // ------------------------------------------------------------
    localparam logic [3:0] NINTH_IDX  = 4'h9;
    localparam logic [3:0] STOP_IDX8  = 4'h9;
    localparam logic [3:0] STOP_IDX9  = 4'hA;
    localparam int         BUF_DEPTH  = 2;
endpackage

// [unbm_baud.sv]
// Purpose: Auto-reload baud timer whose overflow is halved
// Assumes: tick_i is the timer clock enable, one cycle wide
// Notes:   restart_i reloads the count and the halving phase
`timescale 1ns/1ns
module unbm_baud #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // Timer control
    input  wire logic         tick_i,
    input  wire logic         run_i,
    input  wire logic         restart_i,
    input  wire logic [W-1:0] reload_i,
    // Rate pulses
    output logic              half_o,
    output logic              bit_o
);
    logic [W-1:0] cnt_q;
    logic         phase_q;

    // ------------------------------------------------------------
    // Counter; every second overflow ends a bit time
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q   <= '1; // Overflow on first tick; a start bit never outlasts a bit time
            phase_q <= 1'b0;
            half_o  <= 1'b0;
            bit_o   <= 1'b0;
        end
        else
        begin
            half_o <= 1'b0;
            bit_o  <= 1'b0;
            if (restart_i)
            begin
                cnt_q   <= reload_i;
                phase_q <= 1'b0;
            end
            else if (run_i && tick_i)
            begin
                if (&cnt_q)
                begin
                    cnt_q   <= reload_i;
                    phase_q <= ~phase_q;
                    half_o  <= ~phase_q;
                    bit_o   <= phase_q;
                end
                else
                begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end
endmodule

// [unbm_fifo2.sv]
// Purpose: Two-entry word buffer with valid and ready on both sides
// Assumes: Single clock, push and pop may coincide
// Notes:   in_ready_o is registered so it may leave the block directly
`timescale 1ns/1ns
module unbm_fifo2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // Filling side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Draining side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    logic [W-1:0] mem_q [unbm_pkg::BUF_DEPTH];
    logic         wr_ptr_q;
    logic         rd_ptr_q;
    logic [1:0]   cnt_q;
    logic [1:0]   cnt_d;
    logic         push;
    logic         pop;

    // Handshakes
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_ptr_q];

    // Occupancy after this cycle
    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 2'h1;
        else if (pop && !push)
            cnt_d = cnt_q - 2'h1;
    end

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            mem_q[0]   <= '0;
            mem_q[1]   <= '0;
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            cnt_q      <= 2'h0;
            in_ready_o <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_ptr_q] <= in_data_i;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            cnt_q      <= cnt_d;
            in_ready_o <= (cnt_d != 2'h2); // Honest full
        end
    end
endmodule

// [unbm_node.sv]
// Purpose: Remote serial node on the far side of the port
// Assumes: Bit time is a whole number of system clock cycles
// Notes:   Samples at whole bit times, so a short start bit is tolerated
`timescale 1ns/1ns
module unbm_node #(
    parameter int BIT_CYC = 8
) (
    // Serial line
    input  wire logic tx_line_i,
    output logic      rx_line_o,
    // Frame format
    input  wire logic nine_i
);
    logic [9:0] got_q[$];
    logic [9:0] s;

    // ------------------------------------------------------------
    // Sender, full bit times, idle high
    // ------------------------------------------------------------
    initial rx_line_o = 1'b1;
    task automatic send(input logic [7:0] d, input logic b9, input logic stop);
        logic [10:0] bits;
        bits = nine_i ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        #1;
        for (int i = 0; i < (nine_i ? 11 : 10); i++)
        begin
            rx_line_o = bits[i];
            #(BIT_CYC * 10);
        end
        rx_line_o = 1'b1;
        #(BIT_CYC * 10);
    endtask

    // Receiver, stores {stop, ninth, data}
    always @(negedge tx_line_i)
    begin
        #5;
        for (int k = 0; k < (nine_i ? 10 : 9); k++)
        begin
            #(BIT_CYC * 10);
            s[k] = tx_line_i;
        end
        got_q.push_back(nine_i ? s : {s[8], 1'b0, s[7:0]});
    end
endmodule

// [uart_ninth_bit_multidrop_test.sv]
// Purpose: Self-checking bench of the ninth-bit multidrop serial port
// Assumes: Timer tick every cycle, so a bit lasts BIT_CYC cycles
// Notes:   Register and line results are checked against a bench model
`timescale 1ns/1ns
module uart_ninth_bit_multidrop_test;
    localparam logic [7:0] RELOAD  = 8'hFC;
    localparam int         BIT_CYC = 2 * (256 - int'(RELOAD));
    localparam logic [7:0] CA      = unbm_pkg::CTRL_ADDR;
    localparam logic [7:0] DA      = unbm_pkg::SBUF_ADDR;
    logic       ref_clk_i;
    logic       sys_rst_i;
    logic [7:0] sfr_addr_i;
    logic       sfr_wr_i;
    logic       sfr_bit_wr_i;
    logic       sfr_rd_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic       rx_i;
    logic       tx_o;
    logic       irq_req_o;
    logic       tx_buf_ready_o;
    logic       nine_m;
    logic [7:0] ctrl_m;
    logic [7:0] latch_m;
    logic [7:0] v;
    int         err_total;
    int         checks;

    unbm_uart unbm_uart_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_bit_wr_i(sfr_bit_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .t1_tick_i(1'b1), .t1_run_i(1'b1), .baud_reload_value_i(RELOAD),
        .rx_i(rx_i), .tx_o(tx_o), .irq_req_o(irq_req_o),
        .tx_buf_ready_o(tx_buf_ready_o));
    unbm_node #(.BIT_CYC(BIT_CYC)) unbm_node_i (.tx_line_i(tx_o), .rx_line_o(rx_i),
        .nine_i(nine_m));

    // Clock, 100 MHz
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------
    // Bus cycles and compares
    // ------------------------------------------------------------
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input int kind);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= (kind == 0);
        sfr_bit_wr_i <= (kind == 1);
        sfr_rd_i <= (kind == 2);
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
        sfr_bit_wr_i <= 1'b0;
        sfr_rd_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(a, 8'h00, 2);
        #1;
        d = sfr_rdata_o;
    endtask
    task automatic wr_ctrl(input logic [7:0] d);
        cyc(CA, d, 0);
        ctrl_m = d | 8'h40;
    endtask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_frm(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("counts checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog, well beyond the nineteen frames of the run
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] dat[4];
        logic       mce, bv, ren;
        int         w;
        err_total = 0;
        checks = 0;
        {sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_bit_wr_i, sfr_rd_i} = '0;
        nine_m = 1'b0;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        void'($urandom(65));
        ctrl_m = unbm_pkg::CTRL_RESET;
        latch_m = unbm_pkg::SBUF_RESET;
        rd(CA, v);
        cmp_reg(v, ctrl_m);
        rd(DA, v);
        cmp_reg(v, latch_m);
        rd(8'h9A, v);
        cmp_reg(v, 8'h00);
        cmp_reg({7'h00, tx_o}, 8'h01);
        wr_ctrl(8'h00);
        rd(CA, v);
        cmp_reg(v, ctrl_m);
        $display("test reset done");
        // Three formats of transmit; four writes, the last one dropped
        for (int f = 0; f < 3; f++)
        begin
            nine_m = (f != 0);
            wr_ctrl({nine_m, 3'b000, (f != 1), 3'b000});
            for (int j = 0; j < 4; j++)
            begin
                dat[j] = 8'($urandom_range(255));
                cyc(DA, dat[j], 0);
            end
            @(posedge ref_clk_i);
            #1;
            cmp_reg({7'h00, tx_buf_ready_o}, 8'h00);
            cyc(CA + 8'h04, 8'h01, 1);
            ctrl_m[4] = 1'b1;
            for (w = 0; w < 5000 && unbm_node_i.got_q.size() < 3; w++)
                @(posedge ref_clk_i);
            repeat (12 * BIT_CYC) @(posedge ref_clk_i);
            cmp_reg(8'(unbm_node_i.got_q.size()), 8'h03);
            for (int j = 0; j < 3; j++)
                cmp_frm(unbm_node_i.got_q.pop_front(),
                    {1'b1, nine_m & (f != 1), dat[j]});
            ctrl_m[1] = 1'b1;
            rd(CA, v);
            cmp_reg(v, ctrl_m);
            cmp_reg({7'h00, irq_req_o}, 8'h01);
            cyc(CA + 8'h01, 8'h00, 1);
            ctrl_m[1] = 1'b0;
            repeat (3) @(posedge ref_clk_i);
            cmp_reg({7'h00, irq_req_o}, 8'h00);
        end
        $display("test transmit done");
        // Receive: formats, filter, ninth or stop level, done flag already set, disabled
        for (int i = 0; i < 10; i++)
        begin
            nine_m = (i > 7) | i[2];
            mce = (i < 8) ? i[1] : (i == 8);
            bv = (i < 8) ? i[0] : 1'b1;
            ren = (i != 9);
            if (i != 8)
                wr_ctrl({nine_m, 1'b0, mce, ren, 1'b0, ctrl_m[2], 2'b00});
            v = 8'($urandom_range(255));
            @(posedge ref_clk_i);
            unbm_node_i.send(v, bv, nine_m ? ~bv : bv);
            if (ren && !ctrl_m[0] && (!mce || bv))
            begin
                latch_m = v;
                ctrl_m[2] = bv;
                ctrl_m[0] = 1'b1;
            end
            rd(CA, v);
            cmp_reg(v, ctrl_m);
            rd(DA, v);
            cmp_reg(v, latch_m);
        end
        $display("test receive done");
        give_verdict();
    end
endmodule
